// *** fdt_core.sv ***
// flow diagnostics, maintenance countdowns and totalizers
// assumes flow and setpoint in 0.01 % of full scale, synchronous inputs,
// and a parameter port whose read data appear one cycle after the strobe
// Operation
// - zero recommended when zero leaves tolerance band
// - bad zero when result exceeds success band
// - drift check only after minimum drift time
// - expected drift from multiplier and offset
// - read-only total drift since gas page
// - log last 128 zero operations
// - no-flow alarm after settling below limit
// - choked warning or alarm after settling
// - backstream error bit 2 after time limit
// - overhaul countdown hours, due at zero
// - calibration countdown hours, due at zero
// - countdowns decrement only while flowing
// - nonzero countdown write clears due status
// - main totalizer counts up, fully writable
// - overflow warning bit 18, cleared by a write below threshold
// - custom control codes run stop reset
// - control read returns run or stop only
// - reset clears total, keeps prior state
// - gas instance clamped, minimum and default one
// - alarm word bit layout
// - warning word bit layout
// - zero enable starts zero unless inhibited
`include "fdt_params.svh"
`timescale 1ns/100ps
`default_nettype none
module fdt_core
	import fdt_pkg::*;
#(
	parameter int MS_CYCLES = `FDT_CLK_HZ / 1000,
	parameter int S_PER_HOUR = `FDT_S_PER_HOUR,
	parameter int HIST_DEPTH = 128,
	parameter int HIST_AW = 7
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic signed [31:0] flow_i,
	input wire logic signed [31:0] setpoint_i,
	input wire logic flowing_i,
	input wire logic [3:0] flow_limit_flags_i,
	input wire logic [31:0] gas_instances_i,
	input wire logic zero_inhibit_i,
	input wire logic zero_done_i,
	input wire logic signed [31:0] zero_result_i,
	input wire logic [31:0] temperature_i,
	input wire logic [31:0] power_hours_i,
	output logic zero_start_o,
	output logic zero_recommended_o,
	output logic [31:0] errors_o,
	output logic [31:0] alarms_o,
	output logic [31:0] warnings_o
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// true when v lies below pct (0.01 % units) of sp
	function automatic logic below_pct(input logic signed [31:0] v, input logic signed [31:0] sp,
		input logic [31:0] pct);
		logic signed [63:0] lhs;
		logic signed [63:0] rhs;
		lhs = 64'(v) * `FDT_FLOW_SCALE;
		rhs = $signed({32'h00000000, pct}) * 64'(sp);
		return lhs < rhs;
	endfunction

	// settling counter: restarts on a dropped condition, saturates at lim
	function automatic logic [31:0] settle_nxt(input logic [31:0] cnt, input logic cond,
		input logic tick, input logic [31:0] lim);
		if (!cond) begin
			return 32'h00000000;
		end
		if (tick && cnt < lim) begin
			return cnt + 32'h00000001;
		end
		return cnt;
	endfunction

	function automatic logic [31:0] abs32(input logic signed [31:0] v);
		return v[31] ? 32'(-v) : 32'(v);
	endfunction

	// ----------------------------------------------------------------
	// time base: millisecond, second and hour ticks
	// ----------------------------------------------------------------
	logic [31:0] ms_cnt_r; // cycles within a millisecond
	logic [15:0] s_cnt_r; // milliseconds within a second
	logic [15:0] h_cnt_r; // seconds within an hour
	logic ms_tick;
	logic s_tick;
	logic h_tick;
	assign ms_tick = ms_cnt_r == 32'(MS_CYCLES - 1);
	assign s_tick = ms_tick && s_cnt_r == 16'(`FDT_MS_PER_S - 1);
	assign h_tick = s_tick && h_cnt_r == 16'(S_PER_HOUR - 1);

	// free-running dividers, frozen with the clock enable like all state
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ms_cnt_r <= 32'h00000000;
			s_cnt_r <= 16'h0000;
			h_cnt_r <= 16'h0000;
		end else if (ce_i) begin
			ms_cnt_r <= ms_tick ? 32'h00000000 : ms_cnt_r + 32'h00000001;
			if (ms_tick) begin
				s_cnt_r <= s_tick ? 16'h0000 : s_cnt_r + 16'h0001;
			end
			if (s_tick) begin
				h_cnt_r <= h_tick ? 16'h0000 : h_cnt_r + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic [31:0] gas_inst_r; // active calibration instance
	logic [31:0] tol_band_r; // zero tolerance band, 0 disables
	logic [31:0] succ_band_r; // zero success band
	logic [31:0] min_drift_r; // seconds between zeros before drift check
	logic [31:0] mult_r; // drift span multiplier, 16.16
	logic signed [31:0] offs_r; // drift offset
	logic [31:0] noflow_lim_r;
	logic [31:0] noflow_t_r;
	logic [31:0] choke_lim_r;
	logic [31:0] choke_t_r;
	logic [31:0] bs_lim_r;
	logic [31:0] bs_t_r;
	logic [31:0] ovf_thr_r;
	logic [HIST_AW-1:0] hist_idx_r; // 0 selects the newest record
	logic wr_gas;
	assign wr_gas = ce_i && wr_i && addr_i == `FDT_A_GAS_INST;

	// plain settings; writes to read-only locations fall through
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			gas_inst_r <= 32'h00000001;
			tol_band_r <= 32'h00000000;
			succ_band_r <= 32'h00000064;
			min_drift_r <= 32'h00000e10;
			mult_r <= `FDT_RST_MULT;
			offs_r <= 32'sh00000000;
			noflow_lim_r <= 32'h000001f4;
			noflow_t_r <= `FDT_RST_TIME_MS;
			choke_lim_r <= 32'h00001f40;
			choke_t_r <= `FDT_RST_TIME_MS;
			bs_lim_r <= 32'h000001f4;
			bs_t_r <= `FDT_RST_TIME_MS;
			ovf_thr_r <= `FDT_RST_OVF_THR;
			hist_idx_r <= '0;
		end else if (ce_i && wr_i) begin
			case (addr_i)
				`FDT_A_GAS_INST: begin
					// clamp into 1 .. configured instances
					if (wdata_i == 32'h00000000) begin
						gas_inst_r <= 32'h00000001;
					end else if (wdata_i > gas_instances_i && gas_instances_i != 32'h00000000) begin
						gas_inst_r <= gas_instances_i;
					end else begin
						gas_inst_r <= wdata_i;
					end
				end
				`FDT_A_TOL_BAND: tol_band_r <= wdata_i;
				`FDT_A_SUCC_BAND: succ_band_r <= wdata_i;
				`FDT_A_MIN_DRIFT: min_drift_r <= wdata_i;
				`FDT_A_DRIFT_MULT: mult_r <= wdata_i;
				`FDT_A_DRIFT_OFFS: offs_r <= wdata_i;
				`FDT_A_NOFLOW_LIM: noflow_lim_r <= wdata_i;
				`FDT_A_NOFLOW_T: noflow_t_r <= wdata_i;
				`FDT_A_CHOKE_LIM: choke_lim_r <= wdata_i;
				`FDT_A_CHOKE_T: choke_t_r <= wdata_i;
				`FDT_A_BS_LIM: bs_lim_r <= wdata_i;
				`FDT_A_BS_T: bs_t_r <= wdata_i;
				`FDT_A_OVF_THR: ovf_thr_r <= wdata_i;
				`FDT_A_HIST_IDX: hist_idx_r <= wdata_i[HIST_AW-1:0];
				default: ; // other writable locations have their own processes
			endcase
		end
	end

	// ----------------------------------------------------------------
	// zero operation start, recommendation
	// ----------------------------------------------------------------
	// combinational pulse in the write cycle; dropped while inhibited
	assign zero_start_o = ce_i && wr_i && addr_i == `FDT_A_ZERO_EN && wdata_i[0] && !zero_inhibit_i;

	// at 0 % setpoint the measured flow is the live zero
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			zero_recommended_o <= 1'b0;
		end else if (ce_i) begin
			zero_recommended_o <= setpoint_i == 32'sh00000000 && tol_band_r != 32'h00000000
				&& abs32(flow_i) > tol_band_r;
		end
	end

	// ----------------------------------------------------------------
	// zero result evaluation and drift diagnostic
	// ----------------------------------------------------------------
	logic signed [31:0] prev_zero_r; // last successful zero
	logic have_zero_r; // a successful zero exists
	logic [31:0] since_zero_r; // seconds since last successful zero
	logic [31:0] total_drift_r;
	logic bad_zero_r;
	logic drift_warn_r;
	logic signed [31:0] drift;
	logic [31:0] drift_abs;
	logic bad_now;
	logic signed [63:0] expected;
	assign drift = zero_result_i - prev_zero_r;
	assign drift_abs = abs32(drift);
	assign bad_now = abs32(zero_result_i) > succ_band_r;
	// expected drift grows with the interval; 16.16 span plus offset
	assign expected = ((64'($signed({1'b0, mult_r})) * 64'($signed({1'b0, since_zero_r}))) >>> 16)
		+ 64'(offs_r);

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			prev_zero_r <= 32'sh00000000;
			have_zero_r <= 1'b0;
			since_zero_r <= 32'h00000000;
			total_drift_r <= 32'h00000000;
			bad_zero_r <= 1'b0;
			drift_warn_r <= 1'b0;
		end else if (ce_i) begin
			if (s_tick && since_zero_r != 32'hffffffff) begin
				since_zero_r <= since_zero_r + 32'h00000001;
			end
			// a new gas page restarts the drift account
			if (wr_gas) begin
				total_drift_r <= 32'h00000000;
			end
			if (zero_done_i) begin
				bad_zero_r <= bad_now;
				if (!bad_now) begin
					prev_zero_r <= zero_result_i;
					have_zero_r <= 1'b1;
					since_zero_r <= 32'h00000000;
					if (have_zero_r) begin
						total_drift_r <= total_drift_r + drift_abs;
					end
					// too short an interval says nothing about drift
					if (have_zero_r && since_zero_r >= min_drift_r) begin
						drift_warn_r <= 64'($signed({1'b0, drift_abs})) > expected;
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// zero history log
	// ----------------------------------------------------------------
	logic [HIST_AW-1:0] hist_wp_r; // next slot to fill
	logic [HIST_AW:0] hist_cnt_r; // records held, saturates at depth
	logic [HIST_AW-1:0] hist_sel; // index used for the next read
	logic [HIST_AW-1:0] hist_raddr;
	fdt_hist_word_t hist_q;
	// a fresh index write is looked up at once so a read may follow
	assign hist_sel = (ce_i && wr_i && addr_i == `FDT_A_HIST_IDX) ? wdata_i[HIST_AW-1:0] : hist_idx_r;
	assign hist_raddr = hist_wp_r - hist_sel - HIST_AW'(1);

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			hist_wp_r <= '0;
			hist_cnt_r <= '0;
		end else if (ce_i && zero_done_i) begin
			hist_wp_r <= hist_wp_r + HIST_AW'(1);
			if (hist_cnt_r != (HIST_AW+1)'(HIST_DEPTH)) begin
				hist_cnt_r <= hist_cnt_r + (HIST_AW+1)'(1);
			end
		end
	end

	fdt_hist_mem #(
		.DEPTH(HIST_DEPTH),
		.AW(HIST_AW)
	) u_hist (
		.clk_i(clk_i),
		.ce_i(ce_i),
		.we_i(zero_done_i),
		.waddr_i(hist_wp_r),
		.wdata_i({gas_inst_r, drift, temperature_i, power_hours_i}),
		.raddr_i(hist_raddr),
		.rdata_o(hist_q)
	);

	// ----------------------------------------------------------------
	// flow condition settling timers
	// ----------------------------------------------------------------
	logic [31:0] noflow_cnt_r;
	logic [31:0] choke_cnt_r;
	logic [31:0] bs_cnt_r;
	logic noflow_cond;
	logic choke_cond;
	logic bs_cond;
	logic [31:0] choke_alm_lim;
	assign noflow_cond = setpoint_i > 32'sh00000000 && below_pct(flow_i, setpoint_i, noflow_lim_r);
	assign choke_cond = setpoint_i > 32'sh00000000 && below_pct(flow_i, setpoint_i, choke_lim_r);
	assign bs_cond = flow_i < 32'sh00000000 && abs32(flow_i) > bs_lim_r;
	// the alarm needs the condition for twice the warning time
	assign choke_alm_lim = {choke_t_r[30:0], 1'b0};

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			noflow_cnt_r <= 32'h00000000;
			choke_cnt_r <= 32'h00000000;
			bs_cnt_r <= 32'h00000000;
		end else if (ce_i) begin
			noflow_cnt_r <= settle_nxt(noflow_cnt_r, noflow_cond, ms_tick, noflow_t_r);
			choke_cnt_r <= settle_nxt(choke_cnt_r, choke_cond, ms_tick, choke_alm_lim);
			bs_cnt_r <= settle_nxt(bs_cnt_r, bs_cond, ms_tick, bs_t_r);
		end
	end

	// ----------------------------------------------------------------
	// maintenance countdowns
	// ----------------------------------------------------------------
	logic [31:0] overhaul_r;
	logic [31:0] cal_due_r;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			overhaul_r <= `FDT_RST_COUNTDOWN;
			cal_due_r <= `FDT_RST_COUNTDOWN;
		end else if (ce_i) begin
			// a host write wins over a tick in the same cycle
			if (wr_i && addr_i == `FDT_A_OVERHAUL) begin
				overhaul_r <= wdata_i;
			end else if (h_tick && flowing_i && overhaul_r != 32'h00000000) begin
				overhaul_r <= overhaul_r - 32'h00000001;
			end
			if (wr_i && addr_i == `FDT_A_CAL_DUE) begin
				cal_due_r <= wdata_i;
			end else if (h_tick && flowing_i && cal_due_r != 32'h00000000) begin
				cal_due_r <= cal_due_r - 32'h00000001;
			end
		end
	end

	// ----------------------------------------------------------------
	// main and custom totalizers
	// ----------------------------------------------------------------
	logic [31:0] tot_r;
	logic [31:0] ctot_r;
	logic ovf_r;
	fdt_ct_state_t ct_state_r;
	logic [31:0] flow_inc;
	logic wr_tot;
	// only forward flow is accumulated, once per millisecond
	assign flow_inc = (ms_tick && flowing_i && !flow_i[31]) ? 32'(flow_i) : 32'h00000000;
	assign wr_tot = ce_i && wr_i && addr_i == `FDT_A_TOT;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			tot_r <= 32'h00000000;
		end else if (ce_i) begin
			tot_r <= wr_tot ? wdata_i : tot_r + flow_inc;
		end
	end

	// overflow flag: a low write clears it even while the count is above the threshold
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ovf_r <= 1'b0;
		end else if (ce_i) begin
			if (!wr_tot && tot_r > ovf_thr_r) begin
				ovf_r <= 1'b1;
			end else if (wr_tot && wdata_i > ovf_thr_r) begin
				ovf_r <= 1'b1;
			end else if (wr_tot && wdata_i < ovf_thr_r) begin
				ovf_r <= 1'b0;
			end
		end
	end

	// custom totalizer: reset clears the count and leaves the state
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ct_state_r <= FDT_CT_STOP;
			ctot_r <= 32'h00000000;
		end else if (ce_i) begin
			if (ct_state_r == FDT_CT_RUN) begin
				ctot_r <= ctot_r + flow_inc;
			end
			if (wr_i && addr_i == `FDT_A_CTOT) begin
				ctot_r <= wdata_i;
			end
			if (wr_i && addr_i == `FDT_A_CTOT_CTL) begin
				case (wdata_i)
					`FDT_CMD_RUN: ct_state_r <= FDT_CT_RUN;
					`FDT_CMD_STOP: ct_state_r <= FDT_CT_STOP;
					`FDT_CMD_RESET: ctot_r <= 32'h00000000;
					default: ; // unknown codes are ignored
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// status words
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			errors_o <= 32'h00000000;
			alarms_o <= 32'h00000000;
			warnings_o <= 32'h00000000;
		end else if (ce_i) begin
			errors_o <= 32'h00000000;
			errors_o[`FDT_ERR_BACKSTREAM] <= bs_cond && bs_cnt_r >= bs_t_r;
			alarms_o <= 32'h00000000;
			alarms_o[`FDT_ALM_LOW] <= flow_limit_flags_i[0];
			alarms_o[`FDT_ALM_HIGH] <= flow_limit_flags_i[1];
			alarms_o[`FDT_ALM_NOFLOW] <= noflow_cond && noflow_cnt_r >= noflow_t_r;
			alarms_o[`FDT_ALM_CHOKE] <= choke_cond && choke_cnt_r >= choke_alm_lim;
			alarms_o[`FDT_ALM_BAD_GAS] <= gas_inst_r > gas_instances_i;
			warnings_o <= 32'h00000000;
			warnings_o[`FDT_WRN_LOW] <= flow_limit_flags_i[2];
			warnings_o[`FDT_WRN_HIGH] <= flow_limit_flags_i[3];
			warnings_o[`FDT_WRN_CHOKE] <= choke_cond && choke_cnt_r >= choke_t_r;
			warnings_o[`FDT_WRN_DRIFT] <= drift_warn_r;
			warnings_o[`FDT_WRN_BAD_ZERO] <= bad_zero_r;
			warnings_o[`FDT_WRN_CAL_DUE] <= cal_due_r == 32'h00000000;
			warnings_o[`FDT_WRN_OVERFLOW] <= ovf_r;
			warnings_o[`FDT_WRN_OVERHAUL] <= overhaul_r == 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// read port, data one cycle after the strobe
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_o <= 32'h00000000;
		end else if (ce_i && rd_i) begin
			case (addr_i)
				`FDT_A_GAS_INST: rdata_o <= gas_inst_r;
				`FDT_A_TOT: rdata_o <= tot_r;
				`FDT_A_CTOT: rdata_o <= ctot_r;
				`FDT_A_CTOT_CTL: rdata_o <= (ct_state_r == FDT_CT_RUN) ? `FDT_CMD_RUN : `FDT_CMD_STOP;
				`FDT_A_TOL_BAND: rdata_o <= tol_band_r;
				`FDT_A_SUCC_BAND: rdata_o <= succ_band_r;
				`FDT_A_MIN_DRIFT: rdata_o <= min_drift_r;
				`FDT_A_DRIFT_MULT: rdata_o <= mult_r;
				`FDT_A_DRIFT_OFFS: rdata_o <= offs_r;
				`FDT_A_TOTAL_DRIFT: rdata_o <= total_drift_r;
				`FDT_A_NOFLOW_LIM: rdata_o <= noflow_lim_r;
				`FDT_A_NOFLOW_T: rdata_o <= noflow_t_r;
				`FDT_A_CHOKE_LIM: rdata_o <= choke_lim_r;
				`FDT_A_CHOKE_T: rdata_o <= choke_t_r;
				`FDT_A_OVERHAUL: rdata_o <= overhaul_r;
				`FDT_A_CAL_DUE: rdata_o <= cal_due_r;
				`FDT_A_BS_LIM: rdata_o <= bs_lim_r;
				`FDT_A_BS_T: rdata_o <= bs_t_r;
				`FDT_A_OVF_THR: rdata_o <= ovf_thr_r;
				`FDT_A_HIST_IDX: rdata_o <= 32'(hist_idx_r);
				`FDT_A_HIST0: rdata_o <= hist_q[127:96];
				`FDT_A_HIST1: rdata_o <= hist_q[95:64];
				`FDT_A_HIST2: rdata_o <= hist_q[63:32];
				`FDT_A_HIST3: rdata_o <= hist_q[31:0];
				`FDT_A_ERRORS: rdata_o <= errors_o;
				`FDT_A_ALARMS: rdata_o <= alarms_o;
				`FDT_A_WARNINGS: rdata_o <= warnings_o;
				`FDT_A_MISC: rdata_o <= 32'({hist_cnt_r, zero_recommended_o});
				default: rdata_o <= 32'h00000000; // unmapped reads as zero
			endcase
		end
	end
endmodule // fdt_core
`default_nettype wire

// *** fdt_core_assertions.sv ***
// port checker for fdt_core
// assumes inputs held steady while ce_i is low
`timescale 1ns/100ps
`default_nettype none
module fdt_core_assertions(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic signed [31:0] flow_i,
	input wire logic signed [31:0] setpoint_i,
	input wire logic [3:0] flow_limit_flags_i,
	input wire logic zero_inhibit_i,
	input wire logic zero_start_o,
	input wire logic zero_recommended_o,
	input wire logic [31:0] errors_o,
	input wire logic [31:0] alarms_o,
	input wire logic [31:0] warnings_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	zero_start_a:
		assert property (zero_start_o == (wr_i && ce_i && addr_i == 8'h70 && wdata_i[0] && !zero_inhibit_i)) else $error("zero start");
	zero_rec_a:
		assert property (zero_recommended_o |-> $past(setpoint_i) == 0) else $error("zero recommended");
	alarm_bits_a:
		assert property (!$past(reset_i) |-> alarms_o[1:0] == $past(flow_limit_flags_i[1:0])) else $error("alarm bits");
	warn_bits_a:
		assert property (!$past(reset_i) |-> warnings_o[1:0] == $past(flow_limit_flags_i[3:2])) else $error("warn bits");
	back_stream_a:
		assert property ($rose(errors_o[2]) |-> $past(flow_i) < -500) else $error("backstream");
	no_flow_a:
		assert property ($rose(alarms_o[2]) |-> $past(setpoint_i) > 0 && $past(flow_i) < $past(setpoint_i)) else $error("no flow");
	ctl_read_a:
		assert property (rd_i && addr_i == 8'h83 |=> rdata_o inside {32'h1, 32'h2}) else $error("ctl read");
	gas_min_a:
		assert property (wr_i && addr_i == 8'h23 && wdata_i == 0 ##2 rd_i && addr_i == 8'h23 |=> rdata_o == 32'h1) else $error("gas");
	cover property ($rose(alarms_o[2]));
	cover property ($rose(errors_o[2]));
	cover property (zero_start_o);
endmodule // fdt_core_assertions
bind fdt_core fdt_core_assertions chk_u (.*);
`default_nettype wire

// *** fdt_core_tb.sv ***
// self-checking bench for fdt_core through the host model
// assumes shortened ms and hour counts
`timescale 1ns/100ps
`default_nettype none
module fdt_core_tb;
	logic clk_i = 0, reset_i = 1, flowing = 0, inh = 1, zd = 0, ce = 1, wr, rd, zs, zr;
	logic [3:0] fl = 0;
	logic signed [31:0] flow = 0, sp = 0;
	logic [7:0] a;
	logic [31:0] wd, rdata, er, al, wn, v1, zres = 0, tmp = 0, ph = 0;
	int err_count = 0, n_checks = 0, zs_cnt = 0;
	always #20 clk_i = ~clk_i;
	fdt_host_model host(.clk_i(clk_i), .rdata_i(rdata), .addr_o(a), .wdata_o(wd), .wr_o(wr), .rd_o(rd));
	fdt_core #(.MS_CYCLES(4), .S_PER_HOUR(2)) dut(.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce), .addr_i(a),
		.wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .flow_i(flow), .setpoint_i(sp), .flowing_i(flowing),
		.flow_limit_flags_i(fl), .gas_instances_i(32'h4), .zero_inhibit_i(inh), .zero_done_i(zd),
		.zero_result_i(zres), .temperature_i(tmp), .power_hours_i(ph), .zero_start_o(zs),
		.zero_recommended_o(zr), .errors_o(er), .alarms_o(al), .warnings_o(wn));
	task cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// counts zero start pulses as sampled at each edge
	always @(posedge clk_i) begin
		if (zs) zs_cnt++;
	end
	// one zero operation; the spare cycle lets the status word catch up
	task zop(input logic [31:0] r);
		zres <= r;
		tmp <= ~r;
		ph <= r + 32'h10;
		zd <= 1;
		cyc(1);
		zd <= 0;
		cyc(1);
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task rb(input logic [7:0] ad, input int b, input logic e);
		logic [31:0] v;
		host.rd(ad, v);
		chk($sformatf("bit %0d of %h", b, ad), {31'h0, e}, {31'h0, v[b]});
	endtask
	task rc(input logic [7:0] ad, input logic [31:0] e);
		logic [31:0] v;
		host.rd(ad, v);
		chk($sformatf("param %h", ad), e, v);
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		cyc(2);
		reset_i <= 0;
		cyc(1);
		rc(8'h23, 1);
		rc(8'he2, 32'h2710);
		rc(8'h83, 2);
		host.wr(8'h23, 0);
		rc(8'h23, 1);
		host.wr(8'h23, 9);
		rc(8'h23, 4);
		flowing <= 1;
		flow <= 100;
		host.wr(8'h83, 1);
		rc(8'h83, 1);
		cyc(20);
		host.wr(8'h83, 2);
		host.rd(8'h82, v1);
		chk("ctot ran", 1, {31'h0, v1 != 0});
		cyc(20);
		rc(8'h82, v1);
		host.wr(8'h83, 3);
		rc(8'h82, 0);
		rc(8'h83, 2);
		host.wr(8'h83, 1);
		host.wr(8'h83, 3);
		rc(8'h83, 1);
		host.wr(8'h83, 5);
		rc(8'h83, 1);
		host.wr(8'h83, 2);
		flow <= 0;
		host.wr(8'h7e, 32'hf0000001);
		rb(8'hfa, 18, 1);
		host.wr(8'h7e, 5);
		rb(8'hfa, 18, 0);
		rc(8'h7e, 5);
		flow <= 100;
		ce <= 0;
		cyc(20);
		ce <= 1;
		rc(8'h7e, 5);
		flowing <= 0;
		host.wr(8'he2, 1);
		host.wr(8'he3, 1);
		cyc(9000);
		rb(8'hfa, 19, 0);
		flowing <= 1;
		cyc(9000);
		rb(8'hfa, 19, 1);
		rb(8'hfa, 17, 1);
		host.wr(8'he2, 5);
		rb(8'hfa, 19, 0);
		host.wr(8'h8e, 50);
		flow <= 100;
		cyc(3);
		chk("zero rec", 1, {31'h0, zr});
		host.wr(8'h8e, 0);
		cyc(3);
		chk("zero rec off", 0, {31'h0, zr});
		host.wr(8'h70, 1);
		inh <= 0;
		host.wr(8'h70, 1);
		chk("zero starts", 1, zs_cnt);
		zop(200);
		rb(8'hfa, 5, 1);
		zop(20);
		zop(-50);
		rb(8'hfa, 5, 0);
		rb(8'hfa, 4, 0);
		host.wr(8'h90, 0);
		zop(20);
		rb(8'hfa, 4, 1);
		host.wr(8'h92, 100);
		zop(-50);
		rb(8'hfa, 4, 0);
		rc(8'h94, 210);
		host.wr(8'h32, 0);
		rc(8'hf0, 4);
		rc(8'hf1, 32'hffffffba);
		rc(8'hf2, 32'h31);
		rc(8'hf3, 32'hffffffde);
		host.wr(8'h32, 4);
		rc(8'hf1, 32'hc8);
		rc(8'hfb, 32'ha);
		fl <= 4'ha;
		host.wr(8'hdf, 10);
		host.wr(8'he1, 5);
		sp <= 1000;
		flow <= 0;
		cyc(30);
		flow <= 1000;
		cyc(1);
		flow <= 0;
		cyc(30);
		rb(8'hf9, 2, 0);
		rb(8'hf9, 3, 0);
		cyc(30);
		rb(8'hf9, 2, 1);
		rb(8'hf9, 1, 1);
		rb(8'hfa, 1, 1);
		rb(8'hf9, 3, 1);
		rb(8'hfa, 3, 1);
		host.wr(8'he5, 10);
		flow <= -1000;
		cyc(60);
		rb(8'hf8, 2, 1);
		wrap_up();
	end
	initial begin
		cyc(40000);
		err_count++;
		wrap_up();
	end
endmodule // fdt_core_tb
`default_nettype wire

// *** fdt_hist_mem.sv ***
// zero history memory, one record per zero operation
// assumes one write port and one read port on the same clock
`timescale 1ns/100ps
`default_nettype none
module fdt_hist_mem
	import fdt_pkg::*;
#(
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	input wire logic clk_i,
	input wire logic ce_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire fdt_pkg::fdt_hist_word_t wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output var fdt_pkg::fdt_hist_word_t rdata_o
);
	// storage, no reset: contents are only valid up to the record count
	fdt_pkg::fdt_hist_word_t mem [DEPTH];

	// ----------------------------------------------------------------
	// write and registered read
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (ce_i && we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			rdata_o <= mem[raddr_i];
		end
	end
endmodule // fdt_hist_mem
`default_nettype wire

// *** fdt_host_model.sv ***
// host side model: drives the parameter port of fdt_core
// assumes callers start each access just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module fdt_host_model(
	input wire logic clk_i,
	input wire logic [31:0] rdata_i,
	output logic [7:0] addr_o,
	output logic [31:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	initial begin
		{addr_o, wdata_o, wr_o, rd_o} = '0;
	end
	// released lines show the inverse so stale values never pass
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		addr_o <= ad;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~ad;
		wdata_o <= ~d;
		@(posedge clk_i);
	endtask
	// read data stand one cycle after the strobe
	task automatic rd(input logic [7:0] ad, output logic [31:0] d);
		addr_o <= ad;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~ad;
		@(posedge clk_i);
		d = rdata_i;
	endtask
endmodule // fdt_host_model
`default_nettype wire

// *** fdt_params.svh ***
// constants for the flow diagnostics and totalizer block
// assumes an 8-bit parameter address and 32-bit parameter data
`ifndef FDT_PARAMS_SVH
`define FDT_PARAMS_SVH

// ----------------------------------------------------------------
// parameter addresses
// ----------------------------------------------------------------
`define FDT_A_GAS_INST 8'h23
`define FDT_A_ZERO_EN 8'h70
`define FDT_A_TOT 8'h7e
`define FDT_A_CTOT 8'h82
`define FDT_A_CTOT_CTL 8'h83
`define FDT_A_TOL_BAND 8'h8e
`define FDT_A_SUCC_BAND 8'h8f
`define FDT_A_MIN_DRIFT 8'h90
`define FDT_A_DRIFT_MULT 8'h91
`define FDT_A_DRIFT_OFFS 8'h92
`define FDT_A_TOTAL_DRIFT 8'h94
`define FDT_A_NOFLOW_LIM 8'hde
`define FDT_A_NOFLOW_T 8'hdf
`define FDT_A_CHOKE_LIM 8'he0
`define FDT_A_CHOKE_T 8'he1
`define FDT_A_OVERHAUL 8'he2
`define FDT_A_CAL_DUE 8'he3
`define FDT_A_BS_LIM 8'he4
`define FDT_A_BS_T 8'he5
`define FDT_A_OVF_THR 8'he6
`define FDT_A_HIST_IDX 8'h32
`define FDT_A_HIST0 8'hf0
`define FDT_A_HIST1 8'hf1
`define FDT_A_HIST2 8'hf2
`define FDT_A_HIST3 8'hf3
`define FDT_A_ERRORS 8'hf8
`define FDT_A_ALARMS 8'hf9
`define FDT_A_WARNINGS 8'hfa
`define FDT_A_MISC 8'hfb

// ----------------------------------------------------------------
// command codes and status bit positions
// ----------------------------------------------------------------
`define FDT_CMD_RUN 32'h00000001
`define FDT_CMD_STOP 32'h00000002
`define FDT_CMD_RESET 32'h00000003
`define FDT_ERR_BACKSTREAM 2
`define FDT_ALM_LOW 0
`define FDT_ALM_HIGH 1
`define FDT_ALM_NOFLOW 2
`define FDT_ALM_CHOKE 3
`define FDT_ALM_BAD_GAS 15
`define FDT_WRN_LOW 0
`define FDT_WRN_HIGH 1
`define FDT_WRN_CHOKE 3
`define FDT_WRN_DRIFT 4
`define FDT_WRN_BAD_ZERO 5
`define FDT_WRN_CAL_DUE 17
`define FDT_WRN_OVERFLOW 18
`define FDT_WRN_OVERHAUL 19

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define FDT_RST_COUNTDOWN 32'h00002710
`define FDT_RST_OVF_THR 32'hf0000000
`define FDT_RST_MULT 32'h00010000
`define FDT_RST_TIME_MS 32'h000003e8
`define FDT_FLOW_SCALE 64'sd10000
`define FDT_CLK_HZ 25000000
`define FDT_MS_PER_S 1000
`define FDT_S_PER_HOUR 3600

`endif

// *** fdt_pkg.sv ***
// types shared by the flow diagnostics and totalizer block
// assumes nothing of its surroundings
package fdt_pkg;
	// run state of the custom totalizer
	typedef enum logic {
		FDT_CT_STOP,
		FDT_CT_RUN
	} fdt_ct_state_t;
	// one zero history record: instance, drift from the prior zero, temperature, hours
	typedef logic [127:0] fdt_hist_word_t;
endpackage
